// *** pkg/ceaf_pkg.sv ***
// constants, carriers and behaviour summary for the exception and arithmetic flag unit
// Behaviour
// - every exception dispatches through a handler address read from virtual page zero
// - saved pc is the next instruction, pushed in a return block before the handler
// - pending classes are served machine first, then system, then process
// - traps are taken only at an instruction boundary with an extended block
// - faults may be taken mid-instruction and push extra state beyond the block
// - non-global process exceptions use the current ring stack and handler, no ring change
// - only the thread that raised the exception is diverted
// - global exceptions go to a ring 0 handler
// - an enabled arithmetic exception pushes an extended trap frame then jumps
// - integer overflow sets vector or scalar flag, low result bits kept
// - longword multiply overflow keeps bits 0 to 52, upper bits undefined
// - integer divide by zero sets its flag and returns the dividend
// - float divide by zero sets flag, returns reserved operand or NaN
// - float overflow sets flag, forces reserved operand or infinity
// - float underflow sets flag and forces true zero regardless of enable
// - native sign 1 exponent 0 input is reserved; output reserved, zero fraction
// - IEEE NaN input traps and sets the reserved operand flag; here the trap is taken only when E_FLT is set
// - arithmetic groups trap only when enabled; otherwise only flagged
// - each enable covers its own group of status flags
// - status flags stay set until software clears them
// - arithmetic trap handler address is read at offset 0x44 of page zero
package ceaf_pkg;
    localparam logic [7:0] APB_FLAGS = 8'h00;
    localparam logic [7:0] APB_TRAP_EN = 8'h04;
    localparam logic [7:0] APB_STATUS = 8'h08;
    localparam logic [7:0] APB_HANDLER = 8'h0c;
    // status flag positions in processor_status_word
    localparam int F_VIV = 0;
    localparam int F_SCIV = 1;
    localparam int F_VDZ = 2;
    localparam int F_SCDZ = 3;
    localparam int F_FLDZ = 4;
    localparam int F_FOV = 5;
    localparam int F_FUN = 6;
    localparam int F_RSVD = 7;
    localparam int F_INTR = 8;
    localparam int NFLAG = 9;
    // trap enable positions
    localparam int E_IV = 0;
    localparam int E_DZ = 1;
    localparam int E_FLT = 2;
    localparam int E_FU = 3;
    localparam int E_IN = 4;
    localparam int NEN = 5;
    localparam logic [NEN-1:0] TRAP_EN_RST = 5'h00;
    localparam logic [7:0] ARITH_VEC_OFF = 8'h44;
    localparam logic [2:0] RING_KERNEL = 3'h0;
    localparam logic [31:0] WORD_BYTES = 32'h4;
    localparam logic [10:0] EXP_ZERO = 11'h000;
    localparam logic [10:0] EXP_ONES = 11'h7ff;
    // operand fields, shared by the native and ieee layouts
    localparam int FP_SIGN = 63;
    localparam int FP_EXP_HI = 62;
    localparam int FP_EXP_LO = 52;
    localparam int FP_FRAC_HI = 51;
    localparam logic [63:0] NATIVE_RSVD = 64'h8000_0000_0000_0000;
    localparam logic [63:0] IEEE_QNAN = 64'h7ff8_0000_0000_0000;
    localparam logic [62:0] IEEE_INF_MAG = 63'h7ff0_0000_0000_0000;
    localparam logic [63:0] TRUE_ZERO = 64'h0;

    typedef enum logic [2:0] {OP_IADD, OP_IMUL_L, OP_IDIV, OP_FDIV, OP_FOTHER} ceaf_op_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic global_exc;
        logic [7:0] vec_off;
        logic [1:0] tid;
        logic [31:0] next_pc;
        logic [31:0] fault_addr;
    } ceaf_exc_t;

    typedef struct packed {
        logic valid;
        ceaf_op_t op;
        logic vec;
        logic ieee;
        logic int_ovf;
        logic f_ovf;
        logic f_unf;
        logic intrinsic_err;
        logic [1:0] tid;
        logic [31:0] next_pc;
        logic [63:0] a;
        logic [63:0] b;
        logic [63:0] raw;
    } ceaf_arith_in_t;

    typedef struct packed {
        logic valid;
        logic [63:0] result;
    } ceaf_arith_out_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] ring;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ceaf_mem_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] tid;
        logic [2:0] ring;
        logic [31:0] pc;
        logic [31:0] sp;
    } ceaf_redir_t;
endpackage

// *** hdl/ceaf_top.sv ***
// exception sequencer with arithmetic exception detection, flags and apb registers
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module ceaf_top (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire ceaf_pkg::ceaf_exc_t EXC_MACH,
    input wire ceaf_pkg::ceaf_exc_t EXC_SYS,
    input wire ceaf_pkg::ceaf_exc_t EXC_PROC,
    input wire logic BOUNDARY,
    input wire logic [2:0] CUR_RING,
    input wire logic [31:0] CUR_SP,
    input wire logic [31:0] RING0_SP,
    input wire ceaf_pkg::ceaf_arith_in_t ARITH_IN,
    output ceaf_pkg::ceaf_arith_out_t ARITH_OUT,
    output ceaf_pkg::ceaf_mem_req_t MEM_REQ,
    input wire logic MEM_READY,
    input wire logic [31:0] MEM_RDATA,
    output ceaf_pkg::ceaf_redir_t REDIRECT
);
    import ceaf_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_PUSH_PC, S_PUSH_FLAGS, S_PUSH_XTRA, S_FETCH,
                              S_DISPATCH} ceaf_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // arithmetic exception detection
    logic [NFLAG-1:0] flags_q;
    logic [NEN-1:0] trap_en_q;
    logic [NFLAG-1:0] ev;
    logic [NFLAG-1:0] en_mask;
    logic [10:0] a_exp, b_exp;
    logic is_fl, rsvd_in, b_fzero, arith_trap;
    logic [63:0] res_d;

    always_comb begin
        a_exp = ARITH_IN.a[FP_EXP_HI:FP_EXP_LO];
        b_exp = ARITH_IN.b[FP_EXP_HI:FP_EXP_LO];
        is_fl = ARITH_IN.op == OP_FDIV || ARITH_IN.op == OP_FOTHER;
        b_fzero = b_exp == EXP_ZERO && ARITH_IN.b[FP_FRAC_HI:0] == '0;
        rsvd_in = !ARITH_IN.ieee && ((ARITH_IN.a[FP_SIGN] && a_exp == EXP_ZERO)
                || (ARITH_IN.b[FP_SIGN] && b_exp == EXP_ZERO));
        if (ARITH_IN.ieee && (a_exp == EXP_ONES || b_exp == EXP_ONES)) begin
            rsvd_in = 1'b1;
        end
        rsvd_in = rsvd_in && is_fl && ARITH_IN.valid;
        ev = '0;
        ev[F_VIV] = ARITH_IN.valid && !is_fl && ARITH_IN.int_ovf && ARITH_IN.vec;
        ev[F_SCIV] = ARITH_IN.valid && !is_fl && ARITH_IN.int_ovf && !ARITH_IN.vec;
        ev[F_VDZ] = ARITH_IN.valid && ARITH_IN.op == OP_IDIV && ARITH_IN.b == '0
                    && ARITH_IN.vec;
        ev[F_SCDZ] = ARITH_IN.valid && ARITH_IN.op == OP_IDIV && ARITH_IN.b == '0
                    && !ARITH_IN.vec;
        ev[F_FLDZ] = ARITH_IN.valid && ARITH_IN.op == OP_FDIV && b_fzero && !rsvd_in;
        ev[F_FOV] = ARITH_IN.valid && is_fl && ARITH_IN.f_ovf && !rsvd_in;
        ev[F_FUN] = ARITH_IN.valid && is_fl && ARITH_IN.f_unf && !rsvd_in;
        ev[F_RSVD] = rsvd_in;
        ev[F_INTR] = ARITH_IN.valid && ARITH_IN.intrinsic_err;
    end

    always_comb begin
        en_mask = '0;
        en_mask[F_VIV] = trap_en_q[E_IV];
        en_mask[F_SCIV] = trap_en_q[E_IV];
        en_mask[F_VDZ] = trap_en_q[E_DZ];
        en_mask[F_SCDZ] = trap_en_q[E_DZ];
        en_mask[F_FOV] = trap_en_q[E_FLT];
        en_mask[F_RSVD] = trap_en_q[E_FLT];
        en_mask[F_FLDZ] = trap_en_q[E_FLT];
        en_mask[F_FUN] = trap_en_q[E_FU];
        en_mask[F_INTR] = trap_en_q[E_IN];
    end

    // one trap request for all enabled events
    assign arith_trap = |(ev & en_mask);

    always_comb begin
        res_d = ARITH_IN.raw;
        if (rsvd_in) begin
            res_d = ARITH_IN.ieee ? IEEE_QNAN : NATIVE_RSVD;
        end else if (ev[F_FLDZ]) begin
            res_d = ARITH_IN.ieee ? IEEE_QNAN : NATIVE_RSVD;
        end else if (ev[F_FOV]) begin
            res_d = ARITH_IN.ieee ? {ARITH_IN.raw[FP_SIGN], IEEE_INF_MAG} : NATIVE_RSVD;
        end else if (ev[F_FUN]) begin
            res_d = TRUE_ZERO;
        end else if (ev[F_VDZ] || ev[F_SCDZ]) begin
            res_d = ARITH_IN.a;
        end
        // overflow passes the wrapped product, low bits exact
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ARITH_OUT <= '0;
        end else begin
            ARITH_OUT.valid <= ARITH_IN.valid;
            ARITH_OUT.result <= res_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb registers
    logic apb_acc, apb_wr, apb_map;
    logic [NFLAG-1:0] w1c;
    logic [31:0] handler_q;
    ceaf_state_t state_q;

    assign apb_acc = PSEL && PENABLE;
    assign apb_wr = apb_acc && PWRITE;
    assign apb_map = PADDR == APB_FLAGS || PADDR == APB_TRAP_EN || PADDR == APB_STATUS
                     || PADDR == APB_HANDLER;
    // zero wait state slave, error on unmapped offsets
    assign PREADY = 1'b1;
    assign PSLVERR = apb_acc && !apb_map;
    assign w1c = (apb_wr && PADDR == APB_FLAGS) ? PWDATA[NFLAG-1:0] : '0;

    // sticky flags, a new event wins over the clear
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~w1c) | ev;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            trap_en_q <= TRAP_EN_RST;
        end else if (apb_wr && PADDR == APB_TRAP_EN) begin
            trap_en_q <= PWDATA[NEN-1:0];
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PRDATA <= '0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                APB_FLAGS: PRDATA <= 32'(flags_q);
                APB_TRAP_EN: PRDATA <= 32'(trap_en_q);
                APB_STATUS: PRDATA <= 32'(state_q);
                APB_HANDLER: PRDATA <= handler_q;
                default: PRDATA <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending exceptions per class
    ceaf_exc_t mach_q, sys_q, proc_q, proc_new, cur_q;
    logic take, take_m, take_s, take_p, sel_fault;

    always_comb begin
        proc_new = EXC_PROC;
        // an enabled arithmetic exception becomes a process trap
        if (arith_trap) begin
            proc_new = '0;
            proc_new.valid = 1'b1;
            proc_new.vec_off = ARITH_VEC_OFF;
            proc_new.tid = ARITH_IN.tid;
            proc_new.next_pc = ARITH_IN.next_pc;
        end
    end

    assign take_m = mach_q.valid;
    assign take_s = !mach_q.valid && sys_q.valid;
    assign take_p = !mach_q.valid && !sys_q.valid && proc_q.valid;
    assign sel_fault = take_m ? mach_q.fault : take_s ? sys_q.fault : proc_q.fault;
    // traps wait for a boundary, faults do not
    assign take = state_q == S_IDLE && (take_m || take_s || take_p)
                  && (sel_fault || BOUNDARY);

    // a request arriving as its class is taken stays pending
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            mach_q <= '0;
            sys_q <= '0;
            proc_q <= '0;
        end else begin
            if (EXC_MACH.valid) begin
                mach_q <= EXC_MACH;
            end else if (take && take_m) begin
                mach_q.valid <= 1'b0;
            end
            if (EXC_SYS.valid) begin
                sys_q <= EXC_SYS;
            end else if (take && take_s) begin
                sys_q.valid <= 1'b0;
            end
            if (proc_new.valid) begin
                proc_q <= proc_new;
            end else if (take && take_p) begin
                proc_q.valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dispatch sequence
    logic [31:0] sp_q;
    logic [2:0] ring_q;
    logic kernel_sel;
    logic mem_done;

    assign kernel_sel = !take_p || proc_q.global_exc;
    assign mem_done = MEM_REQ.valid && MEM_READY;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: if (take) state_q <= S_PUSH_PC;
                S_PUSH_PC: if (mem_done) state_q <= S_PUSH_FLAGS;
                S_PUSH_FLAGS: if (mem_done) state_q <= cur_q.fault ? S_PUSH_XTRA : S_FETCH;
                S_PUSH_XTRA: if (mem_done) state_q <= S_FETCH;
                S_FETCH: if (mem_done) state_q <= S_DISPATCH;
                S_DISPATCH: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cur_q <= '0;
            ring_q <= RING_KERNEL;
            sp_q <= '0;
        end else if (take) begin
            cur_q <= take_m ? mach_q : take_s ? sys_q : proc_q;
            // non-global process stays in its ring, global and others go to ring 0
            ring_q <= kernel_sel ? RING_KERNEL : CUR_RING;
            sp_q <= kernel_sel ? RING0_SP : CUR_SP;
        end else if (mem_done && state_q != S_FETCH) begin
            sp_q <= sp_q - WORD_BYTES;
        end
    end

    // return block words pushed before the handler fetch
    always_comb begin
        MEM_REQ = '0;
        MEM_REQ.ring = ring_q;
        MEM_REQ.addr = sp_q - WORD_BYTES;
        MEM_REQ.write = 1'b1;
        unique case (state_q)
            S_PUSH_PC: begin
                MEM_REQ.valid = 1'b1;
                MEM_REQ.wdata = cur_q.next_pc;
            end
            S_PUSH_FLAGS: begin
                MEM_REQ.valid = 1'b1;
                MEM_REQ.wdata = 32'({trap_en_q, flags_q});
            end
            S_PUSH_XTRA: begin
                MEM_REQ.valid = 1'b1;
                MEM_REQ.wdata = cur_q.fault_addr;
            end
            S_FETCH: begin
                MEM_REQ.valid = 1'b1;
                MEM_REQ.write = 1'b0;
                MEM_REQ.addr = 32'(cur_q.vec_off);
            end
            default: MEM_REQ.valid = 1'b0;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            handler_q <= '0;
        end else if (state_q == S_FETCH && mem_done) begin
            handler_q <= MEM_RDATA;
        end
    end

    // only the raising thread is redirected
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            REDIRECT <= '0;
        end else begin
            REDIRECT.valid <= state_q == S_FETCH && mem_done;
            REDIRECT.tid <= cur_q.tid;
            REDIRECT.ring <= ring_q;
            REDIRECT.pc <= MEM_RDATA;
            REDIRECT.sp <= sp_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    AST_PRIO: assert property (@(posedge CLOCK) disable iff (RST)
        take && mach_q.valid |=> cur_q.vec_off == $past(mach_q.vec_off))
        else $error("machine class not served first");
    AST_TRAP_BND: assert property (@(posedge CLOCK) disable iff (RST)
        take && !sel_fault |-> BOUNDARY)
        else $error("trap taken off a boundary");
    AST_PC_FIRST: assert property (@(posedge CLOCK) disable iff (RST)
        take |=> MEM_REQ.valid && MEM_REQ.write && MEM_REQ.wdata == cur_q.next_pc)
        else $error("saved pc not pushed first");
    AST_ARITH_VEC: assert property (@(posedge CLOCK) disable iff (RST)
        state_q == S_FETCH && cur_q.vec_off == ARITH_VEC_OFF |-> MEM_REQ.addr == 32'h44)
        else $error("arithmetic vector offset wrong");
    AST_KERNEL: assert property (@(posedge CLOCK) disable iff (RST)
        take && take_p && proc_q.global_exc |=> ring_q == RING_KERNEL)
        else $error("global exception not sent to ring 0");
    AST_LOCAL: assert property (@(posedge CLOCK) disable iff (RST)
        take && take_p && !proc_q.global_exc |=> ring_q == $past(CUR_RING))
        else $error("process exception changed ring");
    AST_STICKY: assert property (@(posedge CLOCK) disable iff (RST)
        flags_q[F_RSVD] && !w1c[F_RSVD] |=> flags_q[F_RSVD])
        else $error("flag lost without software clear");
    AST_DIVZ: assert property (@(posedge CLOCK) disable iff (RST)
        ev[F_SCDZ] |=> ARITH_OUT.result == $past(ARITH_IN.a) && flags_q[F_SCDZ])
        else $error("divide by zero result not dividend");
    AST_UNF: assert property (@(posedge CLOCK) disable iff (RST)
        ev[F_FUN] |=> ARITH_OUT.result == TRUE_ZERO)
        else $error("underflow result not zero");
    AST_MASKED: assert property (@(posedge CLOCK) disable iff (RST)
        ARITH_IN.valid && (ev & en_mask) == '0 && !EXC_PROC.valid |=> !proc_q.valid
        || $past(proc_q.valid))
        else $error("masked exception trapped");
    AST_REDIR: assert property (@(posedge CLOCK) disable iff (RST)
        state_q == S_FETCH && mem_done |=> REDIRECT.valid && REDIRECT.pc == handler_q)
        else $error("handler address not dispatched");

    COV_ARITH_TRAP: cover property (@(posedge CLOCK) disable iff (RST)
        arith_trap ##[1:40] REDIRECT.valid);
    COV_FAULT: cover property (@(posedge CLOCK) disable iff (RST)
        state_q == S_PUSH_XTRA && mem_done);
    COV_MULTI: cover property (@(posedge CLOCK) disable iff (RST)
        ev[F_FOV] && ev[F_INTR]);
endmodule

// *** tb/ceaf_mem_model.sv ***
// memory partner: takes exception pushes, serves handler fetches
`timescale 1ns/1ns
module ceaf_mem_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic slow,
    input wire ceaf_pkg::ceaf_mem_req_t mem_req,
    output logic mem_ready,
    output logic [31:0] mem_rdata
);
    import ceaf_pkg::*;
    logic [2:0] wait_q;
    logic [31:0] word;
    logic [31:0] wr_addr [$];
    logic [31:0] wr_data [$];
    // page zero table: entry tells ring and offset apart
    assign word = 32'h4000_0000 | {13'h0, mem_req.ring, 8'h0, mem_req.addr[7:0]};
    // inverse outside a reply so a stale word never passes
    assign mem_rdata = mem_ready ? word : ~word;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_q <= 3'h0;
            mem_ready <= 1'b0;
        end else begin
            mem_ready <= mem_req.valid && !mem_ready && (wait_q >= (slow ? 3'h3 : 3'h0));
            wait_q <= (mem_req.valid && !mem_ready) ? wait_q + 3'h1 : 3'h0;
            if (mem_req.valid && mem_ready && mem_req.write) begin
                wr_addr.push_back(mem_req.addr);
                wr_data.push_back(mem_req.wdata);
            end
        end
    end
endmodule

// *** tb/ceaf_top_test.sv ***
// self-checking bench for the exception sequencer and arithmetic flags
`timescale 1ns/1ns
module ceaf_top_test;
    import ceaf_pkg::*;
    localparam logic [63:0] K = 64'h1234_5678_9abc_def0;
    localparam logic [63:0] ALL = 64'hffff_ffff_ffff_ffff;
    localparam logic [63:0] L53 = 64'h001f_ffff_ffff_ffff;
    localparam logic [63:0] M63 = 64'h7fff_ffff_ffff_ffff;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, boundary, slow, mrdy;
    logic [7:0] paddr;
    logic [2:0] ring;
    logic [31:0] pwdata, prdata, sp, sp0, mrd;
    ceaf_exc_t em, es, ep;
    ceaf_arith_in_t ai;
    ceaf_arith_out_t ao;
    ceaf_mem_req_t mreq;
    ceaf_redir_t rd;
    ceaf_redir_t rq [$];
    int n_mismatch, tests_run, cyc;
    ceaf_top ceaf_top_i (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXC_MACH(em), .EXC_SYS(es), .EXC_PROC(ep), .BOUNDARY(boundary),
        .CUR_RING(ring), .CUR_SP(sp), .RING0_SP(sp0), .ARITH_IN(ai), .ARITH_OUT(ao),
        .MEM_REQ(mreq), .MEM_READY(mrdy), .MEM_RDATA(mrd), .REDIRECT(rd));
    ceaf_mem_model ceaf_mem_model_i (.clock(clock), .rst(rst), .slow(slow), .mem_req(mreq),
        .mem_ready(mrdy), .mem_rdata(mrd));
    always #20 clock = ~clock;
    always @(posedge clock) begin
        if (rd.valid === 1'b1) begin
            rq.push_back(rd);
        end
        cyc++;
        // far above the few hundred cycles the tests need
        if (cyc > 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] hnd(input logic [2:0] r, input logic [7:0] o);
        return 32'h4000_0000 | {13'h0, r, 8'h0, o};
    endfunction
    function automatic ceaf_arith_in_t mk(input ceaf_op_t o, input logic [5:0] f,
        input logic [63:0] a, input logic [63:0] b, input logic [63:0] raw);
        ceaf_arith_in_t v;
        v = '0;
        {v.vec, v.ieee, v.int_ovf, v.f_ovf, v.f_unf, v.intrinsic_err} = f;
        v.valid = 1'b1;
        v.op = o;
        v.a = a;
        v.b = b;
        v.raw = raw;
        return v;
    endfunction
    task automatic chk(input logic [63:0] g, input logic [63:0] x, input string m);
        tests_run++;
        if (g !== x) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // no local limit: only the bench timeout may end this wait
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic aop(input ceaf_arith_in_t v, output logic [63:0] r);
        @(posedge clock);
        ai <= v;
        @(posedge clock);
        ai.valid <= 1'b0;
        @(negedge clock);
        chk(ao.valid, 1'b1, "strobe");
        r = ao.result;
    endtask
    task automatic wait_redir(input int n);
        int k;
        k = 0;
        while (rq.size() < n && k < 300) begin
            @(posedge clock);
            k++;
        end
        chk(rq.size(), n, "redirects");
    endtask
    task automatic acase(input ceaf_arith_in_t v, input logic [63:0] x,
        input logic [63:0] m, input logic [8:0] f);
        logic [63:0] r;
        logic [31:0] q;
        logic e;
        aop(v, r);
        chk(r & m, x & m, "result");
        aop(mk(OP_IADD, 6'h00, 64'h1, 64'h1, 64'h2), r);
        apb(1'b0, APB_FLAGS, 32'h0, q, e);
        // sticky across a later clean operation
        chk(q, {23'h0, f}, "flag");
        apb(1'b1, APB_FLAGS, 32'h1ff, q, e);
        apb(1'b0, APB_FLAGS, 32'h0, q, e);
        chk(q, 32'h0, "cleared");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        apb(1'b0, APB_TRAP_EN, 32'h0, q, e);
        chk(q, {27'h0, TRAP_EN_RST}, "en reset");
        apb(1'b1, APB_TRAP_EN, 32'h1f, q, e);
        apb(1'b0, APB_TRAP_EN, 32'h0, q, e);
        chk(q, 32'h1f, "en rw");
        apb(1'b1, APB_TRAP_EN, 32'h0, q, e);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk(e, 1'b1, "unmapped");
        chk(q, 32'h0, "unmapped data");
    endtask
    task automatic t_arith();
        acase(mk(OP_IADD, 6'h08, 0, 0, K), K, ALL, 9'h1 << F_SCIV);
        acase(mk(OP_IADD, 6'h28, 0, 0, K), K, ALL, 9'h1 << F_VIV);
        acase(mk(OP_IMUL_L, 6'h08, 0, 0, ~K), ~K, L53, 9'h1 << F_SCIV);
        acase(mk(OP_IDIV, 6'h00, K, 0, 0), K, ALL, 9'h1 << F_SCDZ);
        acase(mk(OP_IDIV, 6'h20, K, 0, 0), K, ALL, 9'h1 << F_VDZ);
        acase(mk(OP_FDIV, 6'h00, K, 0, 0), NATIVE_RSVD, ALL, 9'h1 << F_FLDZ);
        acase(mk(OP_FDIV, 6'h10, K, 0, 0), IEEE_QNAN, ALL, 9'h1 << F_FLDZ);
        acase(mk(OP_FOTHER, 6'h04, K, K, K), NATIVE_RSVD, ALL, 9'h1 << F_FOV);
        acase(mk(OP_FOTHER, 6'h14, K, K, K), {1'b0, IEEE_INF_MAG}, M63, 9'h1 << F_FOV);
        acase(mk(OP_FOTHER, 6'h02, K, K, K), TRUE_ZERO, ALL, 9'h1 << F_FUN);
        acase(mk(OP_FOTHER, 6'h00, 64'h8000_0000_0000_1234, K, K), NATIVE_RSVD, ALL,
            9'h1 << F_RSVD);
        acase(mk(OP_FOTHER, 6'h10, 64'h7ff0_0000_0000_0001, K, K), 0, 0, 9'h1 << F_RSVD);
        acase(mk(OP_FOTHER, 6'h10, 64'hfff0_0000_0000_0000, K, K), 0, 0, 9'h1 << F_RSVD);
        acase(mk(OP_FOTHER, 6'h01, K, K, K), 0, 0, 9'h1 << F_INTR);
        chk(rq.size(), 0, "masked trap");
    endtask
    task automatic t_trap();
        ceaf_arith_in_t v;
        logic [63:0] r;
        logic [31:0] q;
        logic e;
        apb(1'b1, APB_TRAP_EN, 32'h14, q, e);
        boundary <= 1'b0;
        v = mk(OP_FOTHER, 6'h05, K, K, K);
        v.tid = 2'h1;
        v.next_pc = 32'h0000_1230;
        aop(v, r);
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk(mreq.valid, 1'b0, "early push");
        @(posedge clock);
        boundary <= 1'b1;
        wait_redir(1);
        repeat (8) @(posedge clock);
        chk(rq.size(), 1, "one trap");
        chk(rq[0].pc, hnd(3'h2, ARITH_VEC_OFF), "handler");
        chk(rq[0].ring, 3'h2, "ring");
        chk(rq[0].tid, 2'h1, "thread");
        chk(rq[0].sp, 32'h7ff8, "sp");
        chk(ceaf_mem_model_i.wr_addr[0], 32'h7ffc, "pc slot");
        chk(ceaf_mem_model_i.wr_data[0], 32'h1230, "saved pc");
        chk(ceaf_mem_model_i.wr_data[1], {18'h0, 5'h14, 9'h120}, "status word");
        apb(1'b0, APB_HANDLER, 32'h0, q, e);
        chk(q, hnd(3'h2, ARITH_VEC_OFF), "last handler");
        apb(1'b0, APB_STATUS, 32'h0, q, e);
        chk(q, 32'h0, "back to idle");
        apb(1'b1, APB_TRAP_EN, 32'h0, q, e);
        apb(1'b1, APB_FLAGS, 32'h1ff, q, e);
    endtask
    task automatic t_prio();
        rq.delete();
        slow <= 1'b1;
        boundary <= 1'b0;
        @(posedge clock);
        em <= '{valid: 1'b1, vec_off: 8'h08, default: '0};
        es <= '{valid: 1'b1, vec_off: 8'h0c, default: '0};
        ep <= '{valid: 1'b1, global_exc: 1'b1, vec_off: 8'h10, default: '0};
        @(posedge clock);
        em.valid <= 1'b0;
        es.valid <= 1'b0;
        ep.valid <= 1'b0;
        repeat (3) @(posedge clock);
        boundary <= 1'b1;
        wait_redir(3);
        chk(rq[0].pc, hnd(3'h0, 8'h08), "first");
        chk(rq[1].pc, hnd(3'h0, 8'h0c), "second");
        chk(rq[2].pc, hnd(3'h0, 8'h10), "third");
        chk(rq[2].ring, RING_KERNEL, "global ring");
    endtask
    task automatic t_fault();
        rq.delete();
        ceaf_mem_model_i.wr_addr.delete();
        ceaf_mem_model_i.wr_data.delete();
        slow <= 1'b0;
        boundary <= 1'b0;
        @(posedge clock);
        ep <= '{valid: 1'b1, fault: 1'b1, vec_off: 8'h14, fault_addr: 32'h0bad_f00c,
            default: '0};
        @(posedge clock);
        ep.valid <= 1'b0;
        wait_redir(1);
        chk(ceaf_mem_model_i.wr_addr[2], 32'h7ff4, "extra slot");
        chk(ceaf_mem_model_i.wr_data[2], 32'h0bad_f00c, "extra word");
        chk(rq[0].pc, hnd(3'h2, 8'h14), "fault handler");
    endtask
    task end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, slow} = '0;
        {em, es, ep, ai} = '0;
        boundary = 1'b1;
        ring = 3'h2;
        sp = 32'h0000_8000;
        sp0 = 32'h0000_4000;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_arith();
        t_trap();
        t_prio();
        t_fault();
        end_of_test();
    end
endmodule
